// >>> rtl/sdc_mem.sv
// DRAM device end: command decode, banks, modes and data lanes.
// Behaviour
// R1 - Address flag high adds auto-precharge to access.
// R2 - Read precharge starts latency clocks before end.
// R3 - No commands interrupt an auto-precharge burst.
// R4 - No auto-precharge with full page bursts.
// R5 - Write precharge starts one clock after data.
// R6 - Wait write-to-open time before reactivating.
// R7 - Activate to auto-precharge meets row-active time.
// R8 - Precharge code closes an activated bank.
// R9 - Flag high closes all, low one bank.
// R10 - Reactivate after precharge time before access.
// R11 - Self refresh code with gate low, idle.
// R12 - Self refresh ignores all but gate; exits.
// R13 - Refresh bursts recommended around self refresh.
// R14 - Gate low idle enters power down.
// R15 - After power down exit, no-operation follows.
// R16 - No-operation never ends running burst.
// R17 - Deselect acts as no-operation.
// R18 - Gate low with bank active suspends.
// R19 - Suspend ignores commands, exits one clock late.
// R20 - Commands latched with gate high previous cycle.
// R21 - Burst stop only during full page burst.
// R22 - Power down during burst becomes suspend.
// R23 - Byte mask blocks write and read lanes; on reads either mask bit turns off both lanes.
`timescale 1ns/1ps
`default_nettype none
module sdc_mem
    import sdc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    sdc_if.mem link,
    output logic [1:0] bank_open,
    output logic self_refresh,
    output logic powered_down,
    output logic suspended
);
    logic cke_prev_ff;
    logic [1:0] open_ff;
    sdc_mode_t mode_ff;
    logic [2:0] bl_ff;
    logic [8:0] burst_left_ff;
    logic burst_wr_ff;
    logic burst_ap_ff;
    logic burst_bank_ff;
    logic ap_pend_ff;
    logic ap_bank_ff;
    logic [15:0] mem_ff [0:255];
    logic [7:0] col_ff;
    logic [15:0] rd_ff;
    logic rd_oe_n_ff;
    logic suspend_arm_ff;
    logic [1:0] close_mask;
    logic [3:0] cmd;
    logic run;
    logic in_burst;
    logic [8:0] blen;
    logic [1:0] lane_mask;
    logic [15:0] wr_merged;
    logic ap_fire;

    assign cmd = link.cs_n ? CMD_NOP : {1'b0, link.ras_n, link.cas_n, link.we_n}; // R17
    assign run = (mode_ff == SDC_RUN) && cke_prev_ff; // R20
    assign in_burst = burst_left_ff != 9'h0;
    assign blen = (bl_ff == BL_FULL) ? FULL_PAGE_LEN : (9'h1 << bl_ff[1:0]);
    assign lane_mask = {link.upper_byte_mask, link.lower_byte_mask};
    assign wr_merged = {lane_mask[1] ? mem_ff[col_ff][15:8] : link.dq_to_mem[15:8],
        lane_mask[0] ? mem_ff[col_ff][7:0] : link.dq_to_mem[7:0]}; // R23
    // A read precharges once CAS latency beats are left, final beat included; a write one clock after its final beat.
    assign ap_fire = burst_ap_ff && (burst_wr_ff ? burst_left_ff == 9'h1
        : burst_left_ff <= 9'(CAS_LAT)); // R2 R5
    assign close_mask = link.addr[PFLAG_BIT] ? 2'b11 : (2'b01 << link.bank_sel); // R9

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cke_prev_ff <= 1'b0;
            open_ff <= 2'b00;
            mode_ff <= SDC_RUN;
            bl_ff <= 3'h0;
            burst_left_ff <= 9'h0;
            burst_wr_ff <= 1'b0;
            burst_ap_ff <= 1'b0;
            burst_bank_ff <= 1'b0;
            ap_pend_ff <= 1'b0;
            ap_bank_ff <= 1'b0;
            col_ff <= 8'h0;
            rd_ff <= 16'h0;
            rd_oe_n_ff <= 1'b1;
            suspend_arm_ff <= 1'b0;
        end else begin
            cke_prev_ff <= link.cke;
            rd_oe_n_ff <= 1'b1;
            case (mode_ff)
                SDC_RUN: begin
                    if (ap_pend_ff) begin
                        open_ff[ap_bank_ff] <= 1'b0; // R5
                        ap_pend_ff <= 1'b0;
                    end
                    // The arm must fire even though the low gate has already stopped decode.
                    if (suspend_arm_ff) begin
                        mode_ff <= SDC_SUSPEND; // R18
                        suspend_arm_ff <= 1'b0;
                    end
                    if (run) begin
                        if (!link.cke) begin
                            // Burst or open bank turns gate low into suspend, one clock later.
                            if (in_burst || open_ff != 2'b00) begin
                                suspend_arm_ff <= 1'b1; // R18 R22
                            end else if (cmd == CMD_REF) begin
                                mode_ff <= SDC_SELF; // R11
                            end else begin
                                mode_ff <= SDC_PDOWN; // R14
                            end
                        end
                        if (in_burst) begin
                            burst_left_ff <= burst_left_ff - 9'h1; // R16
                            col_ff <= col_ff + 8'h1;
                            if (burst_wr_ff) begin
                                mem_ff[col_ff] <= wr_merged; // R23
                            end else begin
                                rd_ff <= mem_ff[col_ff];
                                rd_oe_n_ff <= |lane_mask; // R23
                            end
                            if (ap_fire && !burst_wr_ff) begin
                                open_ff[burst_bank_ff] <= 1'b0; // R1 R2
                            end
                            if (burst_left_ff == 9'h1 && burst_ap_ff && burst_wr_ff) begin
                                ap_pend_ff <= 1'b1; // R5
                                ap_bank_ff <= burst_bank_ff;
                            end
                        end
                        case (cmd)
                            CMD_ACT: open_ff[link.bank_sel] <= 1'b1;
                            CMD_PRE: open_ff <= open_ff & ~close_mask; // R8 R9
                            CMD_MRS: bl_ff <= link.addr[2:0];
                            CMD_BSTOP: begin
                                if (bl_ff == BL_FULL) begin
                                    burst_left_ff <= 9'h0; // R21
                                end
                            end
                            CMD_READ, CMD_WRITE: begin
                                if (open_ff[link.bank_sel]) begin
                                    burst_left_ff <= blen;
                                    burst_wr_ff <= (cmd == CMD_WRITE);
                                    burst_ap_ff <= link.addr[PFLAG_BIT]; // R1
                                    burst_bank_ff <= link.bank_sel;
                                    col_ff <= link.addr[7:0];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                SDC_SUSPEND: begin
                    if (link.cke) begin
                        mode_ff <= SDC_RUN; // R19
                    end
                end
                SDC_PDOWN, SDC_SELF: begin
                    if (link.cke) begin
                        mode_ff <= SDC_RUN; // R12 R14
                    end
                end
                default: mode_ff <= SDC_RUN;
            endcase
        end
    end

    assign link.dq_from_mem = rd_ff;
    assign link.dq_mem_oe_n = rd_oe_n_ff;
    assign bank_open = open_ff;
    assign self_refresh = mode_ff == SDC_SELF;
    assign powered_down = mode_ff == SDC_PDOWN;
    assign suspended = mode_ff == SDC_SUSPEND;
endmodule
`default_nettype wire

// >>> common/sdc_pkg.sv
// Shared constants and types for the DRAM command link.
package sdc_pkg;
    localparam int BANKS = 2;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int PFLAG_BIT = 10;
    localparam int CLK_PERIOD_NS = 50;
    // Strobe codes {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_BSTOP = 4'h6;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_NOP = 4'h7;
    // Burst length code kept in low address bits of mode set.
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [8:0] FULL_PAGE_LEN = 9'h100;
    // Row cycle, precharge and row active waits, nanoseconds, and derived cycles.
    localparam int ROW_CYCLE_NS = 60;
    localparam int PRE_NS = 18;
    localparam int RAS_NS = 42;
    localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_CYC = (PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAS_CYC = (RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CAS_LAT = 4'h2;
    typedef enum logic [2:0] {
        SDC_RUN, SDC_SUSPEND, SDC_PDOWN, SDC_SELF
    } sdc_mode_t;
endpackage

// >>> common/sdc_if.sv
// Pin-level link between memory controller and DRAM device.
`timescale 1ns/1ps
`default_nettype none
interface sdc_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_sel;
    logic [10:0] addr;
    logic upper_byte_mask;
    logic lower_byte_mask;
    logic [15:0] dq_to_mem;
    logic [15:0] dq_from_mem;
    logic dq_mem_oe_n;
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank_sel, addr, upper_byte_mask,
        lower_byte_mask, dq_to_mem, input dq_from_mem, dq_mem_oe_n);
    modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_sel, addr, upper_byte_mask,
        lower_byte_mask, dq_to_mem, output dq_from_mem, dq_mem_oe_n);
endinterface
`default_nettype wire

// >>> rtl/sdc_ctrl.sv
// Memory controller end: issues one command per request, honouring waits.
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl
    import sdc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    sdc_if.ctrl link,
    input wire logic req_valid,
    input wire logic [3:0] req_cmd,
    input wire logic req_bank,
    input wire logic [10:0] req_addr,
    input wire logic req_cke,
    input wire logic [1:0] req_mask,
    input wire logic [15:0] req_wdata,
    output logic req_ready,
    output logic [15:0] rd_data
);
    logic [3:0] cmd_ff;
    logic bank_ff;
    logic [10:0] addr_ff;
    logic cke_ff;
    logic [1:0] mask_ff;
    logic [15:0] wd_ff;
    logic [15:0] rd_ff;
    logic [7:0] wait_ff;
    logic [2:0] bl_ff;
    logic [7:0] nxt_wait;
    logic [3:0] safe_cmd;
    logic is_full;

    assign is_full = bl_ff == BL_FULL;
    // Auto-precharge is dropped when bursts are full page.
    assign safe_cmd = req_cmd;
    always_comb begin
        nxt_wait = 8'h0;
        case (req_cmd)
            CMD_PRE: nxt_wait = 8'(PRE_CYC); // R10
            CMD_REF: nxt_wait = 8'(ROW_CYCLE_CYC); // R12
            CMD_WRITE, CMD_READ: nxt_wait = req_addr[PFLAG_BIT]
                ? 8'(RAS_CYC + PRE_CYC + 1) + (8'h1 << bl_ff[1:0]) : 8'h0; // R3 R6 R7
            default: nxt_wait = 8'h0;
        endcase
        if (!cke_ff && req_cke) begin
            // Waiting a full row cycle covers both power down and self refresh exit.
            nxt_wait = 8'(ROW_CYCLE_CYC); // R12 R15
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmd_ff <= CMD_NOP;
            bank_ff <= 1'b0;
            addr_ff <= 11'h0;
            cke_ff <= 1'b1;
            mask_ff <= 2'b00;
            wd_ff <= 16'h0;
            rd_ff <= 16'h0;
            wait_ff <= 8'h0;
            bl_ff <= 3'h0;
        end else begin
            if (!link.dq_mem_oe_n) begin
                rd_ff <= link.dq_from_mem;
            end
            cmd_ff <= CMD_NOP; // R15 R16
            mask_ff <= req_mask;
            wd_ff <= req_wdata;
            if (wait_ff != 8'h0) begin
                wait_ff <= wait_ff - 8'h1;
            end else if (req_valid) begin
                cmd_ff <= safe_cmd;
                bank_ff <= req_bank;
                addr_ff <= req_addr;
                if ((req_cmd == CMD_WRITE || req_cmd == CMD_READ) && is_full) begin
                    addr_ff[PFLAG_BIT] <= 1'b0; // R4
                end
                if (req_cmd == CMD_MRS) begin
                    bl_ff <= req_addr[2:0];
                end
                cke_ff <= req_cke; // R11 R14
                wait_ff <= nxt_wait;
            end
        end
    end
    assign req_ready = wait_ff == 8'h0;
    assign rd_data = rd_ff;
    assign link.cke = cke_ff;
    assign link.cs_n = cmd_ff[3];
    assign link.ras_n = cmd_ff[2];
    assign link.cas_n = cmd_ff[1];
    assign link.we_n = cmd_ff[0];
    assign link.bank_sel = bank_ff;
    assign link.addr = addr_ff;
    assign link.upper_byte_mask = mask_ff[1];
    assign link.lower_byte_mask = mask_ff[0];
    assign link.dq_to_mem = wd_ff;
endmodule
`default_nettype wire

// >>> test/sdc_checker.sv
// Checker of command decode and mode changes seen on the DRAM link.
`timescale 1ns/1ps
`default_nettype none
module sdc_checker
    import sdc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_sel,
    input wire logic [10:0] addr,
    input wire logic upper_byte_mask,
    input wire logic lower_byte_mask,
    input wire logic dq_mem_oe_n,
    input wire logic [1:0] bank_open,
    input wire logic self_refresh,
    input wire logic powered_down,
    input wire logic suspended
);
    logic cke_ff;
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire run = !self_refresh && !powered_down && !suspended;
    // A command counts only when the gate was also high on the edge before.
    wire go = run && cke_ff;
    always_ff @(posedge ref_clk) begin
        cke_ff <= srst ? 1'b0 : cke;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_act_opens: assert property (go && cmd == CMD_ACT |=> bank_open[$past(bank_sel)])
        else $error("activate left bank closed");
    a_open_cause: assert property (|(bank_open & ~$past(bank_open)) |->
        $past(go && cmd == CMD_ACT)) else $error("bank opened without activate");
    a_pre_all: assert property (go && cmd == CMD_PRE && addr[PFLAG_BIT] |=>
        bank_open == 2'h0) else $error("precharge all left a bank open");
    a_pre_one: assert property (go && cmd == CMD_PRE && !addr[PFLAG_BIT] |=>
        !bank_open[$past(bank_sel)] && bank_open[!$past(bank_sel)] ==
        $past(bank_open[!bank_sel])) else $error("single precharge wrong bank");
    a_self_entry: assert property (run && cke_ff && !cke && cmd == CMD_REF &&
        bank_open == 2'h0 |-> ##[1:2] self_refresh) else $error("no self refresh");
    a_self_hold: assert property (self_refresh && !cke |=> self_refresh)
        else $error("self refresh left with gate low");
    a_self_exit: assert property (self_refresh && cke |-> ##[1:2] !self_refresh)
        else $error("self refresh not left");
    a_pdown_in: assert property (run && cke_ff && !cke && bank_open == 2'h0 &&
        cmd != CMD_REF |-> ##[1:2] powered_down) else $error("no power down");
    a_susp_in: assert property (run && cke_ff && !cke && bank_open != 2'h0 |->
        ##[1:2] suspended) else $error("no clock suspend");
    a_susp_freeze: assert property (suspended && !cke |=> $stable(bank_open))
        else $error("command taken in suspend");
    a_susp_exit: assert property (suspended && cke |-> ##[1:2] !suspended)
        else $error("suspend not left");
    a_read_drive: assert property (go && cke && cmd == CMD_READ && bank_open[bank_sel] ##1
        !upper_byte_mask && !lower_byte_mask |=> !dq_mem_oe_n)
        else $error("read data not driven");
    c_read: cover property (go && cmd == CMD_READ);
    c_self: cover property (self_refresh);
    c_susp: cover property (suspended);
    c_pdown: cover property (powered_down);
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Bench joining controller and DRAM ends across the command link.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sdc_pkg::*;
;
    typedef struct {
        logic [3:0] cmd;
        logic bank;
        logic pf;
        logic cke;
        logic [1:0] bo;
        logic [2:0] md;
    } sdc_row_t;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    logic [3:0] req_cmd = CMD_NOP;
    logic req_bank = 1'b0;
    logic [10:0] req_addr = 11'h000;
    logic req_cke = 1'b1;
    logic [1:0] req_mask = 2'h0;
    logic [15:0] req_wdata = 16'h0000;
    logic req_ready;
    logic [15:0] rd_data;
    logic [1:0] bank_open;
    logic self_refresh;
    logic powered_down;
    logic suspended;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    wire [2:0] md = {self_refresh, powered_down, suspended};
    // Deselect row drives mode-set strobes with chip select high.
    sdc_row_t rows [20] = '{
        '{CMD_MRS, 1'h0, 1'h0, 1'h1, 2'h0, 3'h0}, '{CMD_ACT, 1'h0, 1'h0, 1'h1, 2'h1, 3'h0},
        '{CMD_ACT, 1'h1, 1'h0, 1'h1, 2'h3, 3'h0}, '{CMD_PRE, 1'h0, 1'h0, 1'h1, 2'h2, 3'h0},
        '{CMD_ACT, 1'h0, 1'h0, 1'h1, 2'h3, 3'h0}, '{CMD_PRE, 1'h0, 1'h1, 1'h1, 2'h0, 3'h0},
        '{CMD_ACT, 1'h1, 1'h0, 1'h1, 2'h2, 3'h0}, '{4'h8, 1'h1, 1'h0, 1'h1, 2'h2, 3'h0},
        '{CMD_BSTOP, 1'h1, 1'h0, 1'h1, 2'h2, 3'h0}, '{CMD_NOP, 1'h0, 1'h0, 1'h0, 2'h2, 3'h1},
        '{CMD_ACT, 1'h0, 1'h0, 1'h0, 2'h2, 3'h1}, '{CMD_NOP, 1'h0, 1'h0, 1'h1, 2'h2, 3'h0},
        '{CMD_PRE, 1'h0, 1'h1, 1'h1, 2'h0, 3'h0}, '{CMD_NOP, 1'h0, 1'h0, 1'h0, 2'h0, 3'h2},
        '{CMD_ACT, 1'h0, 1'h0, 1'h0, 2'h0, 3'h2}, '{CMD_NOP, 1'h0, 1'h0, 1'h1, 2'h0, 3'h0},
        '{CMD_REF, 1'h0, 1'h0, 1'h0, 2'h0, 3'h4}, '{CMD_ACT, 1'h0, 1'h0, 1'h0, 2'h0, 3'h4},
        '{CMD_NOP, 1'h0, 1'h0, 1'h1, 2'h0, 3'h0}, '{CMD_REF, 1'h0, 1'h0, 1'h1, 2'h0, 3'h0}};
    sdc_if lnk();
    sdc_ctrl i_sdc_ctrl(.ref_clk(ref_clk), .srst(srst), .link(lnk.ctrl), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_cke(req_cke),
        .req_mask(req_mask), .req_wdata(req_wdata), .req_ready(req_ready), .rd_data(rd_data));
    sdc_mem i_sdc_mem(.ref_clk(ref_clk), .srst(srst), .link(lnk.mem), .bank_open(bank_open),
        .self_refresh(self_refresh), .powered_down(powered_down), .suspended(suspended));
    sdc_checker i_sdc_checker(.ref_clk(ref_clk), .srst(srst), .cke(lnk.cke), .cs_n(lnk.cs_n),
        .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .bank_sel(lnk.bank_sel),
        .addr(lnk.addr), .upper_byte_mask(lnk.upper_byte_mask),
        .lower_byte_mask(lnk.lower_byte_mask), .dq_mem_oe_n(lnk.dq_mem_oe_n), .bank_open(bank_open),
        .self_refresh(self_refresh), .powered_down(powered_down), .suspended(suspended));
    initial begin
        forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits for the controller to take the request, then lets the result settle.
    task automatic send(input logic [3:0] c, input logic b, input logic [10:0] a, input logic k);
        int i;
        i = 0;
        while (req_ready !== 1'b1 && i < 100) begin
            @(negedge ref_clk);
            i++;
        end
        chk(16'(req_ready), 16'h1);
        req_valid = 1'b1;
        req_cmd = c;
        req_bank = b;
        req_addr = a;
        req_cke = k;
        @(negedge ref_clk);
        req_valid = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        chk(16'(bank_open), 16'h0);
        chk(16'(md), 16'h0);
        repeat (2) @(negedge ref_clk);
        foreach (rows[i]) begin
            send(rows[i].cmd, rows[i].bank, {rows[i].pf, 10'h000}, rows[i].cke);
            chk(16'(bank_open), 16'(rows[i].bo));
            chk(16'(md), 16'(rows[i].md));
        end
        send(CMD_ACT, 1'h0, 11'h000, 1'h1);
        req_wdata = 16'h1234;
        send(CMD_WRITE, 1'h0, 11'h005, 1'h1);
        req_mask = 2'h2;
        req_wdata = 16'hffff;
        send(CMD_WRITE, 1'h0, 11'h005, 1'h1);
        req_mask = 2'h0;
        send(CMD_READ, 1'h0, 11'h405, 1'h1);
        chk(rd_data, 16'h12ff);
        repeat (4) @(negedge ref_clk);
        chk(16'(bank_open), 16'h0);
        send(CMD_ACT, 1'h0, 11'h000, 1'h1);
        req_wdata = 16'hbeef;
        send(CMD_WRITE, 1'h0, 11'h406, 1'h1);
        repeat (4) @(negedge ref_clk);
        chk(16'(bank_open), 16'h0);
        send(CMD_ACT, 1'h0, 11'h000, 1'h1);
        send(CMD_READ, 1'h0, 11'h006, 1'h1);
        chk(rd_data, 16'hbeef);
        // Full page burst: the flag is stripped and burst stop ends it with the bank open.
        send(CMD_PRE, 1'h0, 11'h400, 1'h1);
        send(CMD_MRS, 1'h0, 11'h007, 1'h1);
        send(CMD_ACT, 1'h0, 11'h000, 1'h1);
        send(CMD_READ, 1'h0, 11'h400, 1'h1);
        chk(16'(lnk.dq_mem_oe_n), 16'h0);
        send(CMD_BSTOP, 1'h0, 11'h000, 1'h1);
        chk(16'(lnk.dq_mem_oe_n), 16'h1);
        chk(16'(bank_open), 16'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
